// >>> rtl/btb_trace_unit.sv
// Bus trace and breakpoint unit: registers, triggers, run control
// Behaviour
// R01: Background write of bit 0 resets; reads zero
// R02: Force-reset ignores writes from user program
// R03: Nine debug bytes reachable by application code
// R04: Two 16-bit compare values, reset to zero
// R05: Compare bytes readable always, locked while armed
// R06: FIFO high byte read-only, zero in event modes
// R07: High read holds FIFO, low read advances
// R08: Reader takes high byte before low byte
// R09: Event modes store bytes in low half
// R10: No FIFO advance on low reads while armed
// R11: Unarmed low read stores last opcode address
// R12: Control register accessible at any time
// R13: Enable bit refuses set while secure
// R14: Arm bit starts run, clears at completion
// R15: Tag bit picks break type when enabled
// R16: Break on trigger (end) or full (begin)
// R17: Trigger type never changes break timing
// R18: Comparator A read/write qualification by bits 3:2
// R19: Comparator B read/write qualification by bits 1:0
// R20: Run ends on full or end trigger
// R21: Four-bit trigger mode, nine modes, rest none
// R22: Valid count cleared at start, frozen, max eight
// R23: Comparator hits on equal address and qualification
`timescale 1ns/1ps
module btb_trace_unit
   import btb_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic reg_from_bdc,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic mcu_secure,
   input wire logic cpu_valid,
   input wire logic cpu_read,
   input wire logic cpu_fetch,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_data,
   input wire logic cpu_exec,
   input wire logic [15:0] cpu_exec_addr,
   output logic break_request,
   output logic break_tag,
   output logic force_reset
);
   logic [15:0] cmp_a_q, cmp_a_d, cmp_b_q, cmp_b_d;
   logic [7:0] ctrl_q, ctrl_d, trig_q, trig_d, rdata_q, rdata_d;
   logic [3:0] count_q, count_d;
   logic [15:0] last_fetch_q, last_fetch_d;
   logic match_a_q, match_a_d, match_b_q, match_b_d;
   logic a_seen_q, a_seen_d, follow_q, follow_d;
   logic brk_q, brk_d, tag_q, tag_d, frst_q, frst_d;
   btb_run_type run_q, run_d;
   logic armed, wr_ctrl, start, stop, run_end, event_mode, begin_trace, tag_sel;
   logic cyc, cyc_read, trig, hit_a, hit_b, qual_a, qual_b;
   logic above_a, below_a, above_b, below_b, bdata, ma, mb;
   logic fifo_clear, fifo_push, fifo_shift;
   logic [15:0] cmp_addr, fifo_in, fifo_head;
   logic [3:0] fifo_fill, mode;
   ////////////////////////////////////////////////////////////////////////////////
   // Comparators; tag type watches executed opcodes instead of bus cycles
   assign tag_sel = trig_q[TRG_TYPE];
   assign cmp_addr = tag_sel ? cpu_exec_addr : cpu_addr;
   assign cyc = tag_sel ? cpu_exec : cpu_valid;
   assign cyc_read = tag_sel || cpu_read;
   btb_addr_cmp u_cmp_a (
      .addr(cmp_addr),
      .value(cmp_a_q),
      .cycle_read(cyc_read),
      .dir_en(ctrl_q[CTL_A_DIR_EN]), // [R18]
      .dir(ctrl_q[CTL_A_DIR]),
      .hit(hit_a),
      .qual(qual_a),
      .above(above_a),
      .below(below_a)
   );
   btb_addr_cmp u_cmp_b (
      .addr(cmp_addr),
      .value(cmp_b_q),
      .cycle_read(cyc_read),
      .dir_en(ctrl_q[CTL_B_DIR_EN]), // [R19]
      .dir(ctrl_q[CTL_B_DIR]),
      .hit(hit_b),
      .qual(qual_b),
      .above(above_b),
      .below(below_b)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // Trigger decode per mode
   always_comb
   begin
      ma = cyc && hit_a; // [R23]
      mb = cyc && hit_b; // [R23]
      bdata = cpu_data == cmp_b_q[7:0];
      mode = trig_q[3:0];
      event_mode = btb_event_mode(mode);
      // Event modes always run as begin traces
      begin_trace = trig_q[TRG_BEGIN] || event_mode;
      case (mode) // [R21]
         MODE_A_ONLY: trig = ma;
         MODE_A_OR_B: trig = ma || mb;
         MODE_A_THEN_B: trig = a_seen_q && mb;
         MODE_EVENT_B: trig = mb;
         MODE_A_THEN_EVENT_B: trig = a_seen_q && mb;
         MODE_A_AND_BDATA: trig = ma && bdata;
         MODE_A_NOT_BDATA: trig = ma && !bdata;
         MODE_INSIDE: trig = cyc && qual_a && qual_b && !below_a && !above_b;
         MODE_OUTSIDE: trig = cyc && (below_a || above_b);
         default: trig = 1'b0;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Run control and FIFO feed
   assign armed = run_q != RUN_IDLE;
   assign wr_ctrl = reg_write && (reg_addr == ADDR_CONTROL);
   always_comb
   begin
      run_d = run_q;
      fifo_push = 1'b0;
      fifo_in = cmp_addr;
      run_end = 1'b0;
      // A write of one to both arm and enable, while not secure, begins a run
      start = wr_ctrl && !armed && reg_wdata[CTL_ARM] && reg_wdata[CTL_ENABLE] &&
              !mcu_secure; // [R14]
      stop = wr_ctrl && (!reg_wdata[CTL_ARM] || !reg_wdata[CTL_ENABLE]); // [R14]
      fifo_clear = start;
      case (run_q)
         RUN_IDLE:
         begin
            if (start)
            begin
               run_d = RUN_WAIT;
            end
         end
         RUN_WAIT:
         begin
            if (event_mode)
            begin
               // Only the data byte is kept, high half zero
               fifo_push = trig; // [R09]
               fifo_in = {BYTE_ZERO, cpu_data}; // [R09]
               run_end = trig && (fifo_fill == FILL_LAST); // [R20]
            end
            else if (begin_trace)
            begin
               fifo_push = trig;
               if (trig)
               begin
                  run_d = RUN_STORE;
               end
            end
            else
            begin
               // End trace: circular store of fetched opcode addresses
               fifo_push = cpu_fetch;
               fifo_in = cpu_addr;
               run_end = trig; // [R20]
            end
         end
         RUN_STORE:
         begin
            fifo_push = cpu_fetch;
            fifo_in = cpu_addr;
            run_end = cpu_fetch && (fifo_fill == FILL_LAST); // [R20]
         end
         default: run_d = RUN_IDLE;
      endcase
      if (run_end || stop)
      begin
         run_d = RUN_IDLE; // [R14]
      end
      // Profile read: advance only while not armed
      fifo_shift = reg_read && (reg_addr == ADDR_FIFO_LOW) && !armed; // [R07] [R10] [R11]
   end
   btb_trace_fifo u_fifo (
      .clock(clock),
      .rst(rst),
      .clear(fifo_clear),
      .push(fifo_push),
      .shift_load(fifo_shift),
      .data_in(fifo_shift ? last_fetch_q : fifo_in), // [R11]
      .head(fifo_head),
      .fill(fifo_fill)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // Register writes and run status
   always_comb
   begin
      cmp_a_d = cmp_a_q;
      cmp_b_d = cmp_b_q;
      ctrl_d = ctrl_q;
      trig_d = trig_q;
      frst_d = 1'b0;
      last_fetch_d = cpu_fetch ? cpu_addr : last_fetch_q;
      if (reg_write && !armed) // [R05]
      begin
         case (reg_addr)
            ADDR_CMP_A_HIGH: cmp_a_d[15:8] = reg_wdata;
            ADDR_CMP_A_LOW: cmp_a_d[7:0] = reg_wdata;
            ADDR_CMP_B_HIGH: cmp_b_d[15:8] = reg_wdata;
            ADDR_CMP_B_LOW: cmp_b_d[7:0] = reg_wdata;
            ADDR_TRIGGER: trig_d = reg_wdata & TRG_WRITE_MASK;
            default: trig_d = trig_q;
         endcase
      end
      if (wr_ctrl) // [R12]
      begin
         ctrl_d = reg_wdata;
         ctrl_d[CTL_ENABLE] = reg_wdata[CTL_ENABLE] && !mcu_secure; // [R13]
      end
      // Arm bit mirrors the run state
      ctrl_d[CTL_ARM] = run_d != RUN_IDLE; // [R14]
      // Only a background command may force the reset
      if (reg_write && reg_from_bdc && (reg_addr == ADDR_FORCE_RESET)) // [R02]
      begin
         frst_d = reg_wdata[FORCE_BIT]; // [R01]
      end
      a_seen_d = start ? 1'b0 : (a_seen_q || (armed && ma));
      match_a_d = start ? 1'b0 : (match_a_q || (armed && ma));
      match_b_d = start ? 1'b0 : (match_b_q || (armed && mb));
      // Count follows fill one cycle past the end, then freezes
      follow_d = armed;
      count_d = start ? FILL_ZERO : ((armed || follow_q) ? fifo_fill : count_q); // [R22]
      // Break timing comes only from run end, never from trigger type
      brk_d = run_end && ctrl_q[CTL_BREAK]; // [R16] [R17]
      tag_d = ctrl_q[CTL_BREAK] ? ctrl_q[CTL_TAG] : tag_q; // [R15]
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Read data; unmapped and force-reset indices read zero
   always_comb
   begin
      rdata_d = rdata_q;
      if (reg_read)
      begin
         case (reg_addr) // [R03]
            ADDR_CMP_A_HIGH: rdata_d = cmp_a_q[15:8];
            ADDR_CMP_A_LOW: rdata_d = cmp_a_q[7:0];
            ADDR_CMP_B_HIGH: rdata_d = cmp_b_q[15:8];
            ADDR_CMP_B_LOW: rdata_d = cmp_b_q[7:0];
            ADDR_FIFO_HIGH: rdata_d = event_mode ? BYTE_ZERO : fifo_head[15:8]; // [R06] [R08]
            ADDR_FIFO_LOW: rdata_d = fifo_head[7:0];
            ADDR_CONTROL: rdata_d = ctrl_q;
            ADDR_TRIGGER: rdata_d = trig_q;
            ADDR_STATUS: rdata_d = {match_a_q, match_b_q, armed && ctrl_q[CTL_ENABLE],
                                    1'b0, count_q};
            default: rdata_d = BYTE_ZERO; // [R01]
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cmp_a_q <= 16'h0000; // [R04]
         cmp_b_q <= 16'h0000; // [R04]
         ctrl_q <= BYTE_ZERO;
         trig_q <= BYTE_ZERO;
         rdata_q <= BYTE_ZERO;
         count_q <= FILL_ZERO;
         last_fetch_q <= 16'h0000;
         match_a_q <= 1'b0;
         match_b_q <= 1'b0;
         a_seen_q <= 1'b0;
         follow_q <= 1'b0;
         brk_q <= 1'b0;
         tag_q <= 1'b0;
         frst_q <= 1'b0;
         run_q <= RUN_IDLE;
      end
      else
      begin
         cmp_a_q <= cmp_a_d;
         cmp_b_q <= cmp_b_d;
         ctrl_q <= ctrl_d;
         trig_q <= trig_d;
         rdata_q <= rdata_d;
         count_q <= count_d;
         last_fetch_q <= last_fetch_d;
         match_a_q <= match_a_d;
         match_b_q <= match_b_d;
         a_seen_q <= a_seen_d;
         follow_q <= follow_d;
         brk_q <= brk_d;
         tag_q <= tag_d;
         frst_q <= frst_d;
         run_q <= run_d;
      end
   end
   assign reg_rdata = rdata_q;
   assign break_request = brk_q;
   assign break_tag = tag_q;
   assign force_reset = frst_q;
   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_force_write;
      reg_write && (reg_addr == ADDR_FORCE_RESET) && reg_wdata[FORCE_BIT];
   endsequence
   sequence s_profile_read;
      reg_read && (reg_addr == ADDR_FIFO_LOW) && !armed;
   endsequence
   property p_force_bdc;
      s_force_write ##0 reg_from_bdc |=> force_reset ##1 !force_reset;
   endproperty
   a_force_bdc: assert property (p_force_bdc) // [R01]
      else $error("background force write did not pulse reset");
   property p_force_user;
      s_force_write ##0 !reg_from_bdc |=> !force_reset;
   endproperty
   a_force_user: assert property (p_force_user) // [R02]
      else $error("user write forced a reset");
   property p_force_read;
      reg_read && (reg_addr == ADDR_FORCE_RESET) |=> reg_rdata == BYTE_ZERO;
   endproperty
   a_force_read: assert property (p_force_read) // [R01]
      else $error("force reset register read nonzero");
   property p_cmp_lock;
      armed && reg_write && (reg_addr == ADDR_CMP_A_LOW) |=> $stable(cmp_a_q);
   endproperty
   a_cmp_lock: assert property (p_cmp_lock) // [R05]
      else $error("comparator written while armed");
   property p_cmp_write;
      !armed && reg_write && (reg_addr == ADDR_CMP_B_HIGH) |=>
         cmp_b_q[15:8] == $past(reg_wdata);
   endproperty
   a_cmp_write: assert property (p_cmp_write) // [R04]
      else $error("comparator write lost");
   property p_event_high;
      reg_read && (reg_addr == ADDR_FIFO_HIGH) && event_mode |=> reg_rdata == BYTE_ZERO;
   endproperty
   a_event_high: assert property (p_event_high) // [R06]
      else $error("fifo high byte nonzero in event mode");
   property p_armed_hold;
      reg_read && (reg_addr == ADDR_FIFO_LOW) && armed && !fifo_push && !fifo_clear
         |=> $stable(fifo_head);
   endproperty
   a_armed_hold: assert property (p_armed_hold) // [R10]
      else $error("fifo advanced while armed");
   property p_profile;
      s_profile_read |=> (fifo_fill == FILL_FULL) ##1 $stable(count_q);
   endproperty
   a_profile: assert property (p_profile) // [R11]
      else $error("profile read did not load fifo");
   property p_secure;
      wr_ctrl && mcu_secure |=> !ctrl_q[CTL_ENABLE];
   endproperty
   a_secure: assert property (p_secure) // [R13]
      else $error("enable set while secure");
   property p_break;
      run_end |=> break_request == $past(ctrl_q[CTL_BREAK]);
   endproperty
   a_break: assert property (p_break) // [R16]
      else $error("break request mismatch at run end");
   property p_count;
      start |=> (count_q == FILL_ZERO) ##1 (count_q <= FILL_FULL);
   endproperty
   a_count: assert property (p_count) // [R22]
      else $error("valid count not cleared at run start");
endmodule // btb_trace_unit

// >>> rtl/btb_pkg.sv
// Shared constants and types of the bus trace breakpoint unit
package btb_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // Register indices on the byte register port
   localparam logic [3:0] ADDR_CMP_A_HIGH = 4'h0;
   localparam logic [3:0] ADDR_CMP_A_LOW = 4'h1;
   localparam logic [3:0] ADDR_CMP_B_HIGH = 4'h2;
   localparam logic [3:0] ADDR_CMP_B_LOW = 4'h3;
   localparam logic [3:0] ADDR_FIFO_HIGH = 4'h4;
   localparam logic [3:0] ADDR_FIFO_LOW = 4'h5;
   localparam logic [3:0] ADDR_CONTROL = 4'h6;
   localparam logic [3:0] ADDR_TRIGGER = 4'h7;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_FORCE_RESET = 4'h9;
   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTL_ENABLE = 7;
   localparam int CTL_ARM = 6;
   localparam int CTL_TAG = 5;
   localparam int CTL_BREAK = 4;
   localparam int CTL_A_DIR = 3;
   localparam int CTL_A_DIR_EN = 2;
   localparam int CTL_B_DIR = 1;
   localparam int CTL_B_DIR_EN = 0;
   localparam int TRG_TYPE = 7;
   localparam int TRG_BEGIN = 6;
   localparam int STAT_MATCH_A = 7;
   localparam int STAT_MATCH_B = 6;
   localparam int STAT_ARMED = 5;
   localparam int FORCE_BIT = 0;
   localparam logic [7:0] TRG_WRITE_MASK = 8'hCF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   ////////////////////////////////////////////////////////////////////////////////
   // Trigger mode codes
   localparam logic [3:0] MODE_A_ONLY = 4'h0;
   localparam logic [3:0] MODE_A_OR_B = 4'h1;
   localparam logic [3:0] MODE_A_THEN_B = 4'h2;
   localparam logic [3:0] MODE_EVENT_B = 4'h3;
   localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
   localparam logic [3:0] MODE_A_AND_BDATA = 4'h5;
   localparam logic [3:0] MODE_A_NOT_BDATA = 4'h6;
   localparam logic [3:0] MODE_INSIDE = 4'h7;
   localparam logic [3:0] MODE_OUTSIDE = 4'h8;
   ////////////////////////////////////////////////////////////////////////////////
   // FIFO geometry
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_LAST = 7;
   localparam logic [3:0] FILL_ZERO = 4'h0;
   localparam logic [3:0] FILL_ONE = 4'h1;
   localparam logic [3:0] FILL_FULL = 4'h8;
   localparam logic [3:0] FILL_LAST = 4'h7;
   typedef enum {RUN_IDLE, RUN_WAIT, RUN_STORE} btb_run_type;
   // Event-only modes keep bytes, not addresses
   function automatic logic btb_event_mode(input logic [3:0] mode);
      return (mode == MODE_EVENT_B) || (mode == MODE_A_THEN_EVENT_B);
   endfunction
endpackage

// >>> rtl/btb_addr_cmp.sv
// Address comparator with optional read/write qualification
`timescale 1ns/1ps
module btb_addr_cmp
   import btb_pkg::*;
(
   input wire logic [15:0] addr,
   input wire logic [15:0] value,
   input wire logic cycle_read,
   input wire logic dir_en,
   input wire logic dir,
   output logic hit,
   output logic qual,
   output logic above,
   output logic below
);
   ////////////////////////////////////////////////////////////////////////////////
   // Direction: dir high means reads only, low means writes only
   always_comb
   begin
      qual = !dir_en || (dir == cycle_read);
      hit = qual && (addr == value);
      above = qual && (addr > value);
      below = qual && (addr < value);
   end
endmodule // btb_addr_cmp

// >>> rtl/btb_trace_fifo.sv
// Eight-word trace store with circular push and profile shift
`timescale 1ns/1ps
module btb_trace_fifo
   import btb_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clear,
   input wire logic push,
   input wire logic shift_load,
   input wire logic [15:0] data_in,
   output logic [15:0] head,
   output logic [3:0] fill
);
   logic [15:0] mem_q [FIFO_DEPTH];
   logic [15:0] mem_d [FIFO_DEPTH];
   logic [3:0] fill_q;
   logic [3:0] fill_d;
   logic shift;
   ////////////////////////////////////////////////////////////////////////////////
   // Next contents; a full store drops its oldest word
   always_comb
   begin
      mem_d = mem_q;
      fill_d = fill_q;
      shift = shift_load || (push && (fill_q == FILL_FULL));
      if (clear)
      begin
         fill_d = FILL_ZERO;
      end
      else if (shift)
      begin
         for (int i = 0; i < FIFO_LAST; i++)
         begin
            mem_d[i] = mem_q[i + 1];
         end
         mem_d[FIFO_LAST] = data_in;
         fill_d = FILL_FULL;
      end
      else if (push)
      begin
         mem_d[fill_q[2:0]] = data_in;
         fill_d = fill_q + FILL_ONE;
      end
   end
   // Storage registers
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < FIFO_DEPTH; i++)
         begin
            mem_q[i] <= 16'h0000;
         end
         fill_q <= FILL_ZERO;
      end
      else
      begin
         mem_q <= mem_d;
         fill_q <= fill_d;
      end
   end
   assign head = mem_q[0];
   assign fill = fill_q;
endmodule // btb_trace_fifo

// >>> verification/btb_cpu_model.sv
// Behavioural CPU core bus that feeds the trace unit
`timescale 1ns/1ps
module btb_cpu_model
(
   input wire logic clock,
   output logic cpu_valid,
   output logic cpu_read,
   output logic cpu_fetch,
   output logic [15:0] cpu_addr,
   output logic [7:0] cpu_data,
   output logic cpu_exec,
   output logic [15:0] cpu_exec_addr
);
   ////////////////////////////////////////////////////////////////////////////////
   // Quiet bus at time zero
   initial
   begin
      cpu_valid = 1'b0;
      cpu_read = 1'b1;
      cpu_fetch = 1'b0;
      cpu_addr = 16'hFFFF;
      cpu_data = 8'hFF;
      cpu_exec = 1'b0;
      cpu_exec_addr = 16'hFFFF;
   end
   // One bus cycle; a fetch also counts as executed
   task automatic bus(input logic [15:0] a, input logic rd, input logic f, input logic [7:0] d);
      @(negedge clock);
      cpu_valid = 1'b1;
      cpu_read = rd;
      cpu_fetch = f;
      cpu_addr = a;
      cpu_data = d;
      cpu_exec = f;
      cpu_exec_addr = a;
      @(negedge clock);
      // Released bus shows the inverse, so a stale value never matches
      cpu_valid = 1'b0;
      cpu_fetch = 1'b0;
      cpu_exec = 1'b0;
      cpu_addr = ~a;
      cpu_exec_addr = ~a;
      cpu_data = ~d;
   endtask
endmodule // btb_cpu_model

// >>> verification/btb_trace_unit_tb.sv
// Self-checking bench of the trace unit through its register port
`timescale 1ns/1ps
module btb_trace_unit_tb
   import btb_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic reg_from_bdc = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic mcu_secure = 1'b0;
   logic cpu_valid, cpu_read, cpu_fetch, cpu_exec, break_request, break_tag, force_reset;
   logic [15:0] cpu_addr, cpu_exec_addr;
   logic [7:0] cpu_data;
   int fails = 0;
   int compares = 0;
   int brk_n = 0;
   int force_n = 0;
   int i;
   ////////////////////////////////////////////////////////////////////////////////
   always #5 clock = ~clock;
   btb_trace_unit uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
      .reg_read(reg_read), .reg_from_bdc(reg_from_bdc), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .mcu_secure(mcu_secure), .cpu_valid(cpu_valid),
      .cpu_read(cpu_read), .cpu_fetch(cpu_fetch), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
      .cpu_exec(cpu_exec), .cpu_exec_addr(cpu_exec_addr), .break_request(break_request),
      .break_tag(break_tag), .force_reset(force_reset));
   btb_cpu_model cpu (.clock(clock), .cpu_valid(cpu_valid), .cpu_read(cpu_read),
      .cpu_fetch(cpu_fetch), .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_exec(cpu_exec),
      .cpu_exec_addr(cpu_exec_addr));
   // Pulse counters; a count is easier to judge than a single cycle
   always @(posedge clock)
   begin
      if (break_request === 1'b1) brk_n++;
      if (force_reset === 1'b1) force_n++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Write strobe held for exactly one rising edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic bdc);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_from_bdc = bdc;
      reg_write = 1'b1;
      @(negedge clock);
      reg_write = 1'b0;
      reg_from_bdc = 1'b0;
      reg_wdata = ~d;
   endtask
   // Read, then compare the masked byte half a cycle after the read edge
   task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(negedge clock);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      check({8'h00, reg_rdata & m}, {8'h00, e});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog so a hang still reaches the verdict
   initial
   begin
      repeat (20000) @(posedge clock);
      fails++;
      end_sim();
   end
   initial
   begin
      repeat (6) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      for (i = 0; i < 4; i++) rdc(4'(i), 8'hFF, 8'h00);
      rdc(ADDR_FORCE_RESET, 8'hFF, 8'h00);
      wr(ADDR_FORCE_RESET, 8'h01, 1'b0);
      // A wrong pulse would only be counted one edge later
      @(negedge clock);
      check(16'(force_n), 16'h0000);
      wr(ADDR_FORCE_RESET, 8'h01, 1'b1);
      @(negedge clock);
      check(16'(force_n), 16'h0001);
      rdc(4'hA, 8'hFF, 8'h00);
      wr(ADDR_CMP_A_HIGH, 8'h12, 1'b0);
      wr(ADDR_CMP_A_LOW, 8'h34, 1'b0);
      wr(ADDR_CMP_B_HIGH, 8'h30, 1'b0);
      rdc(ADDR_CMP_A_HIGH, 8'hFF, 8'h12);
      rdc(ADDR_CMP_B_HIGH, 8'hFF, 8'h30);
      // Every mode code; bits 5:4 never stick
      for (i = 0; i < 9; i++)
      begin
         wr(ADDR_TRIGGER, 8'(8'h30 + i), 1'b0);
         rdc(ADDR_TRIGGER, 8'hFF, 8'(i));
      end
      mcu_secure = 1'b1;
      wr(ADDR_CONTROL, 8'h8F, 1'b0);
      rdc(ADDR_CONTROL, 8'hFF, 8'h0F);
      mcu_secure = 1'b0;
      // End trace on comparator A, read cycles only
      wr(ADDR_TRIGGER, 8'h00, 1'b0);
      wr(ADDR_CONTROL, 8'hDC, 1'b0);
      rdc(ADDR_STATUS, 8'h20, 8'h20);
      wr(ADDR_CMP_A_LOW, 8'h55, 1'b0);
      rdc(ADDR_CMP_A_LOW, 8'hFF, 8'h34);
      rdc(ADDR_CONTROL, 8'hFF, 8'hDC);
      for (i = 0; i < 3; i++) cpu.bus(16'(16'h1000 + i), 1'b1, 1'b1, 8'h00);
      cpu.bus(16'h1234, 1'b0, 1'b0, 8'h00);
      repeat (2) @(negedge clock);
      check(16'(brk_n), 16'h0000);
      cpu.bus(16'h1234, 1'b1, 1'b0, 8'h00);
      repeat (2) @(negedge clock);
      check(16'(brk_n), 16'h0001);
      check({15'h0000, break_tag}, 16'h0000);
      rdc(ADDR_STATUS, 8'hEF, 8'h83);
      rdc(ADDR_FIFO_HIGH, 8'hFF, 8'h10);
      rdc(ADDR_FIFO_HIGH, 8'hFF, 8'h10);
      rdc(ADDR_FIFO_LOW, 8'hFF, 8'h00);
      rdc(ADDR_FIFO_HIGH, 8'hFF, 8'h10);
      rdc(ADDR_FIFO_LOW, 8'hFF, 8'h01);
      rdc(ADDR_STATUS, 8'h0F, 8'h03);
      // Profiling: eight low reads bring back the first stored address
      for (i = 0; i < 8; i++)
      begin
         cpu.bus(16'(16'h2460 + i), 1'b1, 1'b1, 8'h00);
         rdc(ADDR_FIFO_LOW, 8'h00, 8'h00);
      end
      rdc(ADDR_FIFO_HIGH, 8'hFF, 8'h24);
      rdc(ADDR_FIFO_LOW, 8'hFF, 8'h60);
      // Reserved mode never triggers; clearing arm stops without a break
      wr(ADDR_TRIGGER, 8'h09, 1'b0);
      wr(ADDR_CONTROL, 8'hD0, 1'b0);
      cpu.bus(16'h1234, 1'b1, 1'b0, 8'h00);
      rdc(ADDR_STATUS, 8'h20, 8'h20);
      wr(ADDR_CONTROL, 8'h80, 1'b0);
      rdc(ADDR_STATUS, 8'h20, 8'h00);
      rdc(ADDR_CONTROL, 8'h40, 8'h00);
      check(16'(brk_n), 16'h0001);
      // Event-only capture on comparator B with tag-type breaks
      wr(ADDR_TRIGGER, 8'h03, 1'b0);
      wr(ADDR_CONTROL, 8'hF1, 1'b0);
      cpu.bus(16'h3000, 1'b1, 1'b0, 8'hEE);
      for (i = 0; i < 8; i++)
      begin
         cpu.bus(16'h3000, 1'b0, 1'b0, 8'(8'h10 + i));
         if (i == 1) rdc(ADDR_FIFO_LOW, 8'hFF, 8'h10);
         if (i == 1) rdc(ADDR_FIFO_LOW, 8'hFF, 8'h10);
      end
      repeat (2) @(negedge clock);
      check(16'(brk_n), 16'h0002);
      check({15'h0000, break_tag}, 16'h0001);
      rdc(ADDR_STATUS, 8'hEF, 8'h48);
      wr(ADDR_FIFO_HIGH, 8'hAA, 1'b0);
      rdc(ADDR_FIFO_HIGH, 8'hFF, 8'h00);
      for (i = 0; i < 8; i++) rdc(ADDR_FIFO_LOW, 8'hFF, 8'(8'h10 + i));
      // Tag type: only an executed opcode at the address triggers
      wr(ADDR_TRIGGER, 8'h80, 1'b0);
      wr(ADDR_CONTROL, 8'hD0, 1'b0);
      cpu.bus(16'h1234, 1'b1, 1'b0, 8'h00);
      repeat (2) @(negedge clock);
      check(16'(brk_n), 16'h0002);
      cpu.bus(16'h1234, 1'b1, 1'b1, 8'h00);
      repeat (2) @(negedge clock);
      check(16'(brk_n), 16'h0003);
      check({15'h0000, break_tag}, 16'h0000);
      end_sim();
   end
endmodule // btb_trace_unit_tb
